//--- include/dwsl_pkg.sv
// Constants and types for the dual wiper serial latch
//==============================================================
// Contract
// - Serial input sampled only on serial clock rising edges; falls shift nothing.
// - Chip select active low, held low per transfer; latch loads on its rise.
// - Both wiper latches preset to midscale 128 at reset, no transfer needed.
// - Each latch holds 8 bits, decoded to exactly one of 256 taps.
// - Code 0x00 selects tap at B end; each increment moves toward A.
// - Wiper-to-A selection is the complement of the tap selection.
// - Word is 9 bits, MSB first: channel bit, then data 7 to 0.
// - While chip select low, one bit shifted per rising serial clock edge.
// - Bits beyond nine: earliest discarded, last nine kept.
package dwsl_pkg;
  localparam int         WORD_BITS    = 9;
  localparam int         CODE_BITS    = 8;
  localparam int         TAP_COUNT    = 256;
  localparam int         CHAN_POS     = 8;
  localparam logic [7:0] MIDSCALE_RST = 8'h80;
  localparam int         SYNC_STAGES  = 2;

  typedef struct packed {
    logic sclk;
    logic serial_input_line;
    logic cs_b;
  } dwsl_serial_s;

  typedef struct packed {
    logic [255:0] tap_b;
    logic [255:0] tap_a;
  } dwsl_taps_s;
endpackage : dwsl_pkg

//--- rtl/dwsl_tap_decode.sv
// One-hot tap decoder for a single wiper latch
`timescale 1ns/1ns
module dwsl_tap_decode
  import dwsl_pkg::*;
#(
  parameter int TAPS = dwsl_pkg::TAP_COUNT
) (
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  input  wire logic [CODE_BITS-1:0] code,
  output dwsl_pkg::dwsl_taps_s      taps_q
);
  import dwsl_pkg::*;

  initial begin
    if (TAPS != (1 << CODE_BITS)) $error("TAPS must equal 2**CODE_BITS");
  end

  dwsl_taps_s taps_d;

  //==============================================================
  // Decode
  always_comb begin
    taps_d = '0;
    taps_d.tap_b[code] = 1'b1;
    taps_d.tap_a = ~taps_d.tap_b;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      taps_q.tap_b <= 256'h1 << MIDSCALE_RST;
      taps_q.tap_a <= ~(256'h1 << MIDSCALE_RST);
    end else begin
      taps_q <= taps_d;
    end
  end

  a_one_hot_tap : assert property (@(posedge clk) disable iff (!rst_b)
    $onehot(taps_q.tap_b)) else $error("Tap selection not one-hot");
  a_tap_follows_code : assert property (@(posedge clk) disable iff (!rst_b)
    ##1 taps_q.tap_b[$past(code)]) else $error("Tap mismatch");
  a_a_complement : assert property (@(posedge clk) disable iff (!rst_b)
    taps_q.tap_a == ~taps_q.tap_b) else $error("A side not complement");
endmodule : dwsl_tap_decode

//--- rtl/dwsl_serial_latch.sv
// Serial shifter and two wiper setting latches
`timescale 1ns/1ns
module dwsl_serial_latch
  import dwsl_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  input  dwsl_pkg::dwsl_serial_s    serial_in,
  output logic [CODE_BITS-1:0]      wiper_setting_latch_one,
  output logic [CODE_BITS-1:0]      wiper_setting_latch_two,
  output dwsl_pkg::dwsl_taps_s      wiper_terminal_one,
  output dwsl_pkg::dwsl_taps_s      wiper_terminal_two
);
  import dwsl_pkg::*;

  //==============================================================
  // Elaboration checks
  // The shifter, channel decode and latch slices assume this word shape
  initial begin
    if (WORD_BITS != CODE_BITS + 1) begin
      $error("Word must be one channel bit plus the code");
    end
    if (CHAN_POS != WORD_BITS - 1) begin
      $error("Channel bit must be the top bit of the word");
    end
    if (SYNC_STAGES != 2) begin
      $error("Only a two stage synchroniser is built");
    end
  end

  //==============================================================
  // Input synchronisers
  // Pins are asynchronous to clk; nothing reads sync1_q but sync2_q.
  // Reset values match the idle pins so no false edge follows reset.
  dwsl_serial_s sync1_q;
  dwsl_serial_s sync2_q;
  dwsl_serial_s prev_q;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sync1_q <= 3'b001;
      sync2_q <= 3'b001;
      prev_q  <= 3'b001;
    end else begin
      sync1_q <= serial_in;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  logic sclk_rise;
  logic cs_rise;
  assign sclk_rise = sync2_q.sclk & ~prev_q.sclk;
  assign cs_rise   = sync2_q.cs_b & ~prev_q.cs_b;

  //==============================================================
  // Shift register
  // Holds only nine bits, so older excess bits fall off the top
  logic [WORD_BITS-1:0] shift_q;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      shift_q <= '0;
    end else if (sclk_rise && !sync2_q.cs_b) begin
      shift_q <= {shift_q[WORD_BITS-2:0], sync2_q.serial_input_line};
    end
  end

  //==============================================================
  // Wiper latches
  // A short frame leaves older bits in the shifter; they are loaded
  // along with the new ones, which the controller must allow for.
  logic [CODE_BITS-1:0] latch_one_q;
  logic [CODE_BITS-1:0] latch_two_q;

  // Loaded only on the select rise, so a partial frame never shows
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      latch_one_q <= MIDSCALE_RST;
    end else if (cs_rise && !shift_q[CHAN_POS]) begin
      latch_one_q <= shift_q[CODE_BITS-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      latch_two_q <= MIDSCALE_RST;
    end else if (cs_rise && shift_q[CHAN_POS]) begin
      latch_two_q <= shift_q[CODE_BITS-1:0];
    end
  end

  assign wiper_setting_latch_one = latch_one_q;
  assign wiper_setting_latch_two = latch_two_q;

  dwsl_tap_decode u_dec_one (
    .clk    (clk),
    .rst_b  (rst_b),
    .code   (latch_one_q),
    .taps_q (wiper_terminal_one)
  );

  dwsl_tap_decode u_dec_two (
    .clk    (clk),
    .rst_b  (rst_b),
    .code   (latch_two_q),
    .taps_q (wiper_terminal_two)
  );

  //==============================================================
  // Checks
  a_no_shift_fall : assert property (@(posedge clk) disable iff (!rst_b)
    !sclk_rise |=> $stable(shift_q)) else $error("Shift without rise");
  a_shift_on_rise : assert property (@(posedge clk) disable iff (!rst_b)
    sclk_rise && !sync2_q.cs_b |=>
    shift_q == {$past(shift_q[7:0]), $past(sync2_q.serial_input_line)})
    else $error("Bad shift");
  a_hold_cs_high : assert property (@(posedge clk) disable iff (!rst_b)
    sync2_q.cs_b |=> $stable(shift_q)) else $error("Shift while idle");
  a_latch_only_rise : assert property (@(posedge clk) disable iff (!rst_b)
    !cs_rise |=> $stable(latch_one_q) && $stable(latch_two_q))
    else $error("Latch changed without select rise");
  a_chan_zero_load : assert property (@(posedge clk) disable iff (!rst_b)
    cs_rise && !shift_q[8] |=> latch_one_q == $past(shift_q[7:0]) &&
    $stable(latch_two_q)) else $error("Channel one load wrong");
  a_chan_one_load : assert property (@(posedge clk) disable iff (!rst_b)
    cs_rise && shift_q[8] |=> latch_two_q == $past(shift_q[7:0]) &&
    $stable(latch_one_q)) else $error("Channel two load wrong");
  a_reset_mid : assert property (@(posedge clk)
    !rst_b |=> latch_one_q == 8'h80 && latch_two_q == 8'h80)
    else $error("Not midscale after reset");
  a_last_nine : assert property (@(posedge clk) disable iff (!rst_b)
    sclk_rise && !sync2_q.cs_b |=> shift_q[8] == $past(shift_q[7]))
    else $error("Excess bit kept");

  c_load_one : cover property (@(posedge clk) cs_rise && !shift_q[8]);
  c_load_two : cover property (@(posedge clk) cs_rise && shift_q[8]);
  c_shift_bit : cover property (@(posedge clk) sclk_rise && !sync2_q.cs_b);

  //==============================================================
  // Frame bit counter
  // Observation only; saturates so a long frame cannot wrap to nine
  logic [3:0] bits_seen_q;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      bits_seen_q <= 4'h0;
    end else if (sync2_q.cs_b) begin
      bits_seen_q <= 4'h0;
    end else if (sclk_rise && bits_seen_q != 4'hf) begin
      bits_seen_q <= bits_seen_q + 4'h1;
    end
  end

  c_long_frame : cover property (@(posedge clk)
    cs_rise && bits_seen_q > 4'h9);
  c_short_frame : cover property (@(posedge clk)
    cs_rise && bits_seen_q < 4'h9 && bits_seen_q != 4'h0);

  //==============================================================
  // Output checks
  // Taps trail the latch by one cycle because the decoder is registered
  a_term_one_code : assert property (@(posedge clk) disable iff (!rst_b)
    ##1 wiper_terminal_one.tap_b[$past(latch_one_q)])
    else $error("Terminal one tap wrong");
  a_term_two_code : assert property (@(posedge clk) disable iff (!rst_b)
    ##1 wiper_terminal_two.tap_b[$past(latch_two_q)])
    else $error("Terminal two tap wrong");
  a_term_one_inv : assert property (@(posedge clk) disable iff (!rst_b)
    wiper_terminal_one.tap_a == ~wiper_terminal_one.tap_b)
    else $error("Terminal one A side wrong");
  a_term_two_inv : assert property (@(posedge clk) disable iff (!rst_b)
    wiper_terminal_two.tap_a == ~wiper_terminal_two.tap_b)
    else $error("Terminal two A side wrong");
  a_reset_taps : assert property (@(posedge clk)
    !rst_b |=> wiper_terminal_one.tap_b[MIDSCALE_RST] &&
    wiper_terminal_two.tap_b[MIDSCALE_RST])
    else $error("Taps not midscale after reset");
  a_term_one_hot : assert property (@(posedge clk) disable iff (!rst_b)
    $onehot(wiper_terminal_one.tap_b))
    else $error("Terminal one not one-hot");
  a_term_two_hot : assert property (@(posedge clk) disable iff (!rst_b)
    $onehot(wiper_terminal_two.tap_b))
    else $error("Terminal two not one-hot");
  a_rise_single : assert property (@(posedge clk) disable iff (!rst_b)
    sclk_rise |=> !sclk_rise)
    else $error("Serial clock rise seen twice");
  a_out_one_latch : assert property (@(posedge clk) disable iff (!rst_b)
    wiper_setting_latch_one == latch_one_q)
    else $error("Latch one output differs");
  a_out_two_latch : assert property (@(posedge clk) disable iff (!rst_b)
    wiper_setting_latch_two == latch_two_q)
    else $error("Latch two output differs");
endmodule : dwsl_serial_latch

//--- tb/dwsl_spi_host.sv
// Serial controller model driving the latch's three pins
`timescale 1ns/1ns
module dwsl_spi_host
  import dwsl_pkg::*;
(
  input  wire logic             clk,
  output dwsl_pkg::dwsl_serial_s ser
);
  initial ser = '{sclk: 1'b0, serial_input_line: 1'b0, cs_b: 1'b1};
  // Half of a 160 ns serial period, counted in system clocks
  task automatic half;
    repeat (4) @(negedge clk);
  endtask : half
  // Data changes only while the serial clock is low
  task automatic send(input logic [15:0] w, input int n);
    ser.cs_b = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      ser.serial_input_line = w[i];
      half();
      ser.sclk = 1'b1;
      half();
      ser.sclk = 1'b0;
    end
    half();
    ser.cs_b = 1'b1;
    ser.serial_input_line = ~ser.serial_input_line;
    half();
  endtask : send
  // Clock pulse with the device deselected
  task automatic stray;
    ser.serial_input_line = 1'b1;
    half();
    ser.sclk = 1'b1;
    half();
    ser.sclk = 1'b0;
  endtask : stray
endmodule : dwsl_spi_host

//--- tb/testbench.sv
// Self-checking bench for the dual wiper serial latch
`timescale 1ns/1ns
module testbench;
  import dwsl_pkg::*;
  logic         clk = 1'b0;
  logic         rst_b = 1'b0;
  dwsl_serial_s ser;
  logic [7:0]   one;
  logic [7:0]   two;
  dwsl_taps_s   t_one;
  dwsl_taps_s   t_two;
  int           failures = 0;
  int           tests_run = 0;
  always #10 clk = ~clk;
  dwsl_spi_host u_dwsl_spi_host (.clk(clk), .ser(ser));
  dwsl_serial_latch u_dwsl_serial_latch (
    .clk(clk), .rst_b(rst_b), .serial_in(ser),
    .wiper_setting_latch_one(one), .wiper_setting_latch_two(two),
    .wiper_terminal_one(t_one), .wiper_terminal_two(t_two));
  task automatic chk(input logic [255:0] got, input logic [255:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %0h want %0h", $time, got, exp);
    end
  endtask : chk
  // Waits out sync and decode latency before looking
  task automatic expect_w(input logic [7:0] a, input logic [7:0] b);
    repeat (4) @(negedge clk);
    chk(one, a);
    chk(two, b);
    chk(t_one.tap_b, 256'h1 << a);
    chk(t_two.tap_b, 256'h1 << b);
    chk(t_one.tap_a, ~(256'h1 << a));
    chk(t_two.tap_a, ~(256'h1 << b));
  endtask : expect_w
  task automatic t_writes;
    u_dwsl_spi_host.send(16'h0000, 9);
    expect_w(8'h00, 8'h80);
    u_dwsl_spi_host.send(16'h01ff, 9);
    expect_w(8'h00, 8'hff);
    $display("test writes done");
  endtask : t_writes
  // Two excess leading bits must drop out
  task automatic t_long;
    u_dwsl_spi_host.send(16'h065a, 11);
    expect_w(8'h5a, 8'hff);
    $display("test long frame done");
  endtask : t_long
  task automatic t_stray;
    u_dwsl_spi_host.stray();
    expect_w(8'h5a, 8'hff);
    // A stray shift would move a 1 into the channel bit of this frame
    u_dwsl_spi_host.send(16'h00c3, 8);
    expect_w(8'hc3, 8'hff);
    $display("test deselected clock done");
  endtask : t_stray
  task automatic finish_test;
    $display("checks %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test
  initial begin
    repeat (6) @(negedge clk);
    rst_b = 1'b1;
    expect_w(8'h80, 8'h80);
    $display("test reset done");
    t_writes();
    t_long();
    t_stray();
    finish_test();
  end
  // Frames take a few microseconds; this leaves ample margin
  initial begin
    #100000;
    failures++;
    finish_test();
  end
endmodule : testbench
